// >>> card_host_decode_and_config.sv
// Host port decode, lane steering and attribute configuration registers of the card
`timescale 1ns/1ns

//
// Overview of operation
// - Task file reachable I/O-mapped or memory-mapped, byte, word and odd-byte access.
// - I/O byte read puts even or odd byte on D7..D0, D15..D8 floats.
// - I/O write takes byte lanes per access type on trailing IOWR edge.
// - Memory-mapped access uses the same steering with REG high and OE/WE.
// - True IDE chosen only if OE grounded at power-on; attribute space then closed.
// - True IDE data register is word wide; core 8-bit mode narrows CS0 cycles, DMA cycles stay word wide.
// - IDE CS0 at address 0 moves a data word; addresses 1..7 a low byte.
// - IDE CS1 address 6 is alternate status/device control; both selects low floats.
// - Configuration registers work in memory and I/O modes, not True IDE.
// - Soft-reset bit holds card reset until cleared; hardware reset clears it.
// - Option bit 6 selects pulse (0) or level (1) interrupt requests.
// - Six-bit index selects task file mapping; zero after any reset.
// - Primary I/O decodes 1F0-1F7, 3F6-3F7; secondary 170-177, 376-377.
// - STSCHG low when I/O mode, change enable set and status changed set.
// - Byte-bus-only bit turns word cycles (both enables low) into byte cycles on D7..D0.
// - Power-down bit change shows busy on ready until power state reached.
// - Interrupt pending follows core request, reads zero when interrupts disabled.
// - Ready-change latch sets on ready change, host writable under mirror mask; reset 0CH.
module card_host_decode_and_config
    import card_host_pkg::*;
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Host socket pins
    input wire logic i_ce1_n,
    input wire logic i_ce2_n,
    input wire logic i_reg_n,
    input wire logic i_oe_n,
    input wire logic i_we_n,
    input wire logic i_iord_n,
    input wire logic i_iowr_n,
    input wire logic i_dmack_n,
    input wire logic i_reset_pin,
    input wire logic [10:0] i_addr,
    input wire logic [15:0] i_data,
    output logic [15:0] o_data,
    output logic [15:0] o_data_oe,
    output logic o_ready,
    output logic o_stschg_n,
    output logic o_irq,
    // Card core side
    input wire logic i_core_ready,
    input wire logic i_sleeping,
    input wire logic i_irq_req,
    input wire logic i_ide_8bit,
    input wire logic [15:0] i_tf_rdata,
    output logic o_tf_rd,
    output logic o_tf_wr,
    output logic o_tf_dma,
    output logic [3:0] o_tf_addr,
    output logic [15:0] o_tf_wdata,
    output logic [1:0] o_tf_be,
    output logic o_card_reset,
    output logic o_true_ide,
    output logic o_power_down
);

    typedef struct packed {
        pin_t s1;
        pin_t s2;
        pin_t prev;
        logic [1:0] por_cnt;
        logic por_done;
        logic ide;
        logic [7:0] opt;
        logic [7:0] cfgstat;
        logic [7:0] pinrep;
        logic [7:0] socket;
        logic ien_n;
        logic ready_prev;
        logic pwr_busy;
        logic pend_prev;
        logic [2:0] pulse_cnt;
        logic tf_rd;
        logic tf_wr;
        logic tf_dma;
        logic [3:0] tf_addr;
        logic [15:0] tf_wdata;
        logic [1:0] tf_be;
        logic [15:0] data;
        logic [15:0] data_oe;
        logic ready;
        logic stschg_n;
        logic irq;
        logic card_reset;
    } state_t;

    state_t st_reg;
    state_t st_next;

    // Pin decode into one access; pure function so current and previous samples share it
    function automatic acc_t decode(input pin_t p, input logic ide, input logic [5:0] idx,
                                    input logic byte_only, input logic ide8);
        acc_t a;
        logic b0;
        logic hit;
        a = '0;
        b0 = 1'b0;
        hit = 1'b0;
        if (ide) begin
            if (!p.dmack_n && p.ce1_n && p.ce2_n) begin
                a.dma = 1'b1;
                a.tf = 1'b1;
                a.tf_addr = TF_DATA;
                a.lanes = 2'b11;
            end else if (p.dmack_n && !p.ce1_n && p.ce2_n) begin
                a.tf = 1'b1;
                a.tf_addr = {1'b0, p.addr[2:0]};
                a.lanes = (p.addr[2:0] == 3'h0 && !ide8) ? 2'b11 : 2'b01;
            end else if (p.dmack_n && p.ce1_n && !p.ce2_n && p.addr[2:0] == IDE_ALT_ADDR) begin
                a.tf = 1'b1;
                a.tf_addr = TF_ALT;
                a.lanes = 2'b01;
            end
            a.rd = a.tf && !p.iord_n;
            a.wr = a.tf && !p.iowr_n;
        end else begin
            // Lane steering from chip enables
            unique case ({p.ce2_n, p.ce1_n})
                2'b10: begin
                    a.lanes = 2'b01;
                    b0 = p.addr[0];
                end
                2'b00: begin
                    a.lanes = byte_only ? 2'b01 : 2'b11;
                    b0 = byte_only ? p.addr[0] : 1'b0;
                end
                2'b01: begin
                    a.lanes = 2'b10;
                    b0 = 1'b0;
                end
                2'b11: begin
                    a.lanes = 2'b00;
                    b0 = 1'b0;
                end
            endcase
            if (a.lanes != 2'b00) begin
                if (p.reg_n && (!p.oe_n || !p.we_n) && idx == IDX_MEM
                    && (p.addr[10] || p.addr[9:4] == 6'h00)) begin
                    a.tf = 1'b1;
                    a.tf_addr = {p.addr[3:1], b0};
                    a.rd = !p.oe_n && p.iord_n;
                    a.wr = !p.we_n && p.iowr_n;
                end else if (!p.reg_n && (!p.iord_n || !p.iowr_n)) begin
                    // I/O windows per mapping index
                    unique case (idx)
                        IDX_CONTIG: begin
                            hit = 1'b1;
                            a.tf_addr = {p.addr[3:1], b0};
                        end
                        IDX_PRI: begin
                            hit = (p.addr[9:3] == PRI_BASE[9:3]) || (p.addr[9:1] == PRI_ALT[9:1]);
                            a.tf_addr = (p.addr[9:3] == PRI_BASE[9:3]) ? {1'b0, p.addr[2:1], b0} : {3'h7, b0};
                        end
                        IDX_SEC: begin
                            hit = (p.addr[9:3] == SEC_BASE[9:3]) || (p.addr[9:1] == SEC_ALT[9:1]);
                            a.tf_addr = (p.addr[9:3] == SEC_BASE[9:3]) ? {1'b0, p.addr[2:1], b0} : {3'h7, b0};
                        end
                        default: begin
                            hit = 1'b0;
                            a.tf_addr = 4'h0;
                        end
                    endcase
                    a.tf = hit;
                    a.rd = hit && !p.iord_n && p.oe_n;
                    a.wr = hit && !p.iowr_n && p.we_n;
                end else if (!p.reg_n && (!p.oe_n || !p.we_n) && a.lanes[0] && b0 == 1'b0) begin
                    a.cfg = 1'b1;
                    a.cfg_addr = {p.addr[10:1], 1'b0};
                    a.lanes = 2'b01;
                    a.rd = !p.oe_n;
                    a.wr = !p.we_n;
                end
            end
            if (!a.tf && !a.cfg) begin
                a.lanes = 2'b00;
            end
        end
        return a;
    endfunction : decode

    acc_t cur;
    acc_t prv;
    logic pin_rst;
    logic card_rst;
    logic io_mode;
    logic pend;
    logic ready_now;
    logic pulse_start;
    logic [7:0] cfg_val;

    // Next-state logic for the whole port
    always_comb begin
        st_next = st_reg;
        st_next.s1 = '{ce1_n: i_ce1_n, ce2_n: i_ce2_n, reg_n: i_reg_n, oe_n: i_oe_n, we_n: i_we_n,
                       iord_n: i_iord_n, iowr_n: i_iowr_n, dmack_n: i_dmack_n, rst_pin: i_reset_pin,
                       addr: i_addr, data: i_data};
        st_next.s2 = st_reg.s1;
        st_next.prev = st_reg.s2;
        st_next.tf_rd = 1'b0;
        st_next.tf_wr = 1'b0;

        // Mode strap caught once the synchroniser has settled after power-on
        if (!st_reg.por_done) begin
            st_next.por_cnt = st_reg.por_cnt + 2'h1;
            if (st_reg.por_cnt == POR_SETTLE) begin
                st_next.por_done = 1'b1;
                st_next.ide = !st_reg.s2.oe_n;
            end
        end

        // Hard reset pin is active low only in True IDE
        pin_rst = st_reg.ide ? !st_reg.s2.rst_pin : st_reg.s2.rst_pin;
        card_rst = pin_rst || st_reg.opt[OPT_SRST_BIT] || !st_reg.por_done;
        io_mode = !st_reg.ide && st_reg.opt[5:0] != IDX_MEM;
        pend = i_irq_req && !st_reg.ien_n;

        cur = decode(st_reg.s2, st_reg.ide, st_reg.opt[5:0], st_reg.cfgstat[CS_HOST_BYTE_BUS_ONLY_BIT], i_ide_8bit);
        prv = decode(st_reg.prev, st_reg.ide, st_reg.opt[5:0], st_reg.cfgstat[CS_HOST_BYTE_BUS_ONLY_BIT], i_ide_8bit);

        cfg_val = 8'h00;
        if (cur.cfg_addr == OPT_ADDR) begin
            cfg_val = st_reg.opt;
        end else if (cur.cfg_addr == CFGSTAT_ADDR) begin
            cfg_val = {st_reg.pinrep[PR_CRDY_BIT], st_reg.cfgstat[CS_SIG_BIT], st_reg.cfgstat[CS_HOST_BYTE_BUS_ONLY_BIT],
                       2'b00, st_reg.cfgstat[CS_PWD_BIT], pend, 1'b0};
        end else if (cur.cfg_addr == PINREP_ADDR) begin
            cfg_val = {2'b00, st_reg.pinrep[PR_CRDY_BIT], 1'b0, 2'b11, st_reg.ready, 1'b0};
        end else if (cur.cfg_addr == SOCKET_ADDR) begin
            cfg_val = {3'b000, st_reg.socket[SK_COPY_BIT], 4'h0};
        end

        // Read: lanes driven while the strobe stays low; core gets one start pulse
        if (cur.rd && !card_rst) begin
            st_next.data_oe = {{8{cur.lanes[1]}}, {8{cur.lanes[0]}}};
            st_next.data = cur.cfg ? {8'h00, cfg_val} : i_tf_rdata;
            if (cur.tf && !(prv.rd && prv.tf)) begin
                st_next.tf_rd = 1'b1;
                st_next.tf_addr = cur.tf_addr;
                st_next.tf_dma = cur.dma;
            end
        end else begin
            st_next.data_oe = 16'h0000;
        end

        // Write: data taken on the trailing edge of the strobe
        if (prv.wr && !cur.wr && !card_rst && prv.tf) begin
            st_next.tf_wr = 1'b1;
            st_next.tf_addr = prv.tf_addr;
            st_next.tf_dma = prv.dma;
            st_next.tf_be = prv.lanes;
            st_next.tf_wdata = st_reg.prev.data;
            if (prv.tf_addr == TF_ALT && prv.lanes[0]) begin
                st_next.ien_n = st_reg.prev.data[CTL_IEN_BIT];
            end
        end
        if (prv.wr && !cur.wr && prv.cfg && !st_reg.ide) begin
            if (prv.cfg_addr == OPT_ADDR) begin
                st_next.opt = st_reg.prev.data[7:0];
            end else if (prv.cfg_addr == CFGSTAT_ADDR) begin
                st_next.cfgstat[CS_SIG_BIT] = st_reg.prev.data[CS_SIG_BIT];
                st_next.cfgstat[CS_HOST_BYTE_BUS_ONLY_BIT] = st_reg.prev.data[CS_HOST_BYTE_BUS_ONLY_BIT];
                st_next.cfgstat[CS_PWD_BIT] = st_reg.prev.data[CS_PWD_BIT];
            end else if (prv.cfg_addr == PINREP_ADDR && st_reg.prev.data[PR_RRDY_BIT]) begin
                st_next.pinrep[PR_CRDY_BIT] = st_reg.prev.data[PR_CRDY_BIT];
            end else if (prv.cfg_addr == SOCKET_ADDR) begin
                st_next.socket[SK_COPY_BIT] = st_reg.prev.data[SK_COPY_BIT];
            end
        end

        // Power state change: settle clears busy, a fresh change sets it again
        if (st_reg.pwr_busy && i_sleeping == st_reg.cfgstat[CS_PWD_BIT]) begin
            st_next.pwr_busy = 1'b0;
        end
        if (st_next.cfgstat[CS_PWD_BIT] != st_reg.cfgstat[CS_PWD_BIT]) begin
            st_next.pwr_busy = 1'b1;
        end

        // Ready mirror and change latch; hardware set beats host clear
        ready_now = i_core_ready && !st_reg.pwr_busy && !card_rst;
        st_next.ready = ready_now;
        st_next.ready_prev = st_reg.ready;
        if (st_reg.ready != st_reg.ready_prev) begin
            st_next.pinrep[PR_CRDY_BIT] = 1'b1;
        end

        // Configuration state cleared by card reset; soft bit only by hardware
        if (card_rst) begin
            st_next.opt = {st_next.opt[OPT_SRST_BIT] && !pin_rst, 7'h00};
            st_next.cfgstat = CFGSTAT_RST;
            st_next.pinrep = PINREP_RST;
            st_next.socket = SOCKET_RST;
            st_next.ien_n = 1'b0;
            st_next.pwr_busy = 1'b0;
        end

        st_next.stschg_n = !(io_mode && st_next.cfgstat[CS_SIG_BIT] && st_next.pinrep[PR_CRDY_BIT]);

        // Interrupt style: level follows pending, pulse is a fixed width per rising event
        pulse_start = pend && !st_reg.pend_prev;
        st_next.pend_prev = pend;
        if (pulse_start) begin
            st_next.pulse_cnt = IRQ_PULSE_CYC;
        end else if (st_reg.pulse_cnt != 3'h0) begin
            st_next.pulse_cnt = st_reg.pulse_cnt - 3'h1;
        end
        st_next.irq = (io_mode || st_reg.ide) && !card_rst &&
                      (st_reg.opt[OPT_LVL_BIT] ? pend : st_next.pulse_cnt != 3'h0);
        st_next.card_reset = card_rst;
    end

    // State register; strobes and selects idle high, reset pin low, everything else at its reset value
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            st_reg <= '0;
            st_reg.s1 <= PIN_IDLE;
            st_reg.s2 <= PIN_IDLE;
            st_reg.prev <= PIN_IDLE;
            st_reg.opt <= OPT_RST;
            st_reg.cfgstat <= CFGSTAT_RST;
            st_reg.pinrep <= PINREP_RST;
            st_reg.socket <= SOCKET_RST;
            st_reg.stschg_n <= 1'b1;
            st_reg.card_reset <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    // Outputs straight from the state register
    assign o_data = st_reg.data;
    assign o_data_oe = st_reg.data_oe;
    assign o_ready = st_reg.ready;
    assign o_stschg_n = st_reg.stschg_n;
    assign o_irq = st_reg.irq;
    assign o_tf_rd = st_reg.tf_rd;
    assign o_tf_wr = st_reg.tf_wr;
    assign o_tf_dma = st_reg.tf_dma;
    assign o_tf_addr = st_reg.tf_addr;
    assign o_tf_wdata = st_reg.tf_wdata;
    assign o_tf_be = st_reg.tf_be;
    assign o_card_reset = st_reg.card_reset;
    assign o_true_ide = st_reg.ide;
    assign o_power_down = st_reg.cfgstat[CS_PWD_BIT];

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    a_standby_floats: assert property (!st_reg.ide && st_reg.s2.ce1_n && st_reg.s2.ce2_n |=> o_data_oe == 16'h0000)
        else $error("standby did not float the bus");
    a_soft_reset_hold: assert property (st_reg.opt[OPT_SRST_BIT] |=> o_card_reset && st_reg.opt[5:0] == 6'h00)
        else $error("soft reset not holding card");
    a_ide_no_config: assert property (st_reg.ide && st_reg.por_done && !o_card_reset |=> $stable(st_reg.opt))
        else $error("config register changed in true ide");
    a_stschg_follow: assert property (##1 o_stschg_n == !($past(!st_reg.ide && st_reg.opt[5:0] != IDX_MEM)
                                      && st_reg.cfgstat[CS_SIG_BIT] && st_reg.pinrep[PR_CRDY_BIT]))
        else $error("status change pin wrong");
    a_pwd_busy: assert property ($changed(st_reg.cfgstat[CS_PWD_BIT]) && !o_card_reset |=> !o_ready)
        else $error("ready not busy after power change");
    a_irq_masked: assert property (st_reg.ien_n && st_reg.opt[OPT_LVL_BIT] |=> !o_irq)
        else $error("interrupt seen while disabled");
    a_level_irq: assert property (st_reg.opt[OPT_LVL_BIT] && $past(st_reg.opt[OPT_LVL_BIT]) && !card_rst
                                  && i_irq_req && !st_reg.ien_n && (io_mode || st_reg.ide) |=> o_irq)
        else $error("level interrupt not held");
    a_pulse_width: assert property ((!st_reg.opt[OPT_LVL_BIT] && i_irq_req && !st_reg.ien_n)[*8] |-> !o_irq)
        else $error("pulse width wrong");
    a_pulse_len: assert property ($rose(o_irq) && !st_reg.opt[OPT_LVL_BIT] |-> o_irq[*5] ##1 !o_irq)
        else $error("interrupt pulse length wrong");
    a_word_lanes: assert property (!st_reg.ide && !o_card_reset && cur.rd && cur.tf && cur.lanes == 2'b11
                                   |=> o_data_oe == 16'hFFFF)
        else $error("word read did not drive both lanes");
    a_fixed_bits: assert property (cur.rd && cur.cfg && !o_card_reset && cur.cfg_addr == PINREP_ADDR
                                   |=> (o_data[7:0] & PR_FIXED_ONES) == PR_FIXED_ONES)
        else $error("fixed pin replacement bits wrong");

    c_ide_word: cover property (st_reg.ide && o_tf_rd && o_tf_addr == TF_DATA);
    c_soft_reset: cover property ($fell(st_reg.opt[OPT_SRST_BIT]));
    c_pulse_irq: cover property ($rose(o_irq) && !st_reg.opt[OPT_LVL_BIT]);
    c_cfg_write: cover property (prv.wr && !cur.wr && prv.cfg);

endmodule : card_host_decode_and_config

// >>> card_host_pkg.sv
// Shared constants and carrier types for the card host port decode block
package card_host_pkg;

    // Attribute-space configuration register addresses
    localparam logic [10:0] OPT_ADDR = 11'h200;
    localparam logic [10:0] CFGSTAT_ADDR = 11'h202;
    localparam logic [10:0] PINREP_ADDR = 11'h204;
    localparam logic [10:0] SOCKET_ADDR = 11'h206;

    // Reset values
    localparam logic [7:0] OPT_RST = 8'h00;
    localparam logic [7:0] CFGSTAT_RST = 8'h00;
    localparam logic [7:0] PINREP_RST = 8'h0C;
    localparam logic [7:0] SOCKET_RST = 8'h00;

    // Field positions
    localparam int OPT_SRST_BIT = 7;
    localparam int OPT_LVL_BIT = 6;
    localparam int CS_SIG_BIT = 6;
    localparam int CS_HOST_BYTE_BUS_ONLY_BIT = 5;
    localparam int CS_PWD_BIT = 2;
    localparam int PR_CRDY_BIT = 5;
    localparam int PR_RRDY_BIT = 1;
    localparam int SK_COPY_BIT = 4;
    localparam int CTL_IEN_BIT = 1;
    localparam logic [7:0] PR_FIXED_ONES = 8'h0C;

    // Task file mapping index codes
    localparam logic [5:0] IDX_MEM = 6'h00;
    localparam logic [5:0] IDX_CONTIG = 6'h01;
    localparam logic [5:0] IDX_PRI = 6'h02;
    localparam logic [5:0] IDX_SEC = 6'h03;

    // I/O decode windows
    localparam logic [9:0] PRI_BASE = 10'h1F0;
    localparam logic [9:0] PRI_ALT = 10'h3F6;
    localparam logic [9:0] SEC_BASE = 10'h170;
    localparam logic [9:0] SEC_ALT = 10'h376;

    // Task file register numbers seen by the core
    localparam logic [3:0] TF_DATA = 4'h0;
    localparam logic [3:0] TF_ALT = 4'hE;
    localparam logic [2:0] IDE_ALT_ADDR = 3'h6;

    // Timing
    localparam int CLK_PERIOD_NS = 100;
    localparam int IRQ_PULSE_NS = 500;
    localparam int IRQ_PULSE_CYC_INT = (IRQ_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [2:0] IRQ_PULSE_CYC = 3'(IRQ_PULSE_CYC_INT);
    localparam logic [1:0] POR_SETTLE = 2'h3;

    // Sampled host pins
    typedef struct packed {
        logic ce1_n;
        logic ce2_n;
        logic reg_n;
        logic oe_n;
        logic we_n;
        logic iord_n;
        logic iowr_n;
        logic dmack_n;
        logic rst_pin;
        logic [10:0] addr;
        logic [15:0] data;
    } pin_t;

    localparam pin_t PIN_IDLE = '{ce1_n: 1'b1, ce2_n: 1'b1, reg_n: 1'b1, oe_n: 1'b1, we_n: 1'b1,
                                  iord_n: 1'b1, iowr_n: 1'b1, dmack_n: 1'b1, rst_pin: 1'b0,
                                  addr: 11'h000, data: 16'h0000};

    // Decoded access
    typedef struct packed {
        logic rd;
        logic wr;
        logic tf;
        logic cfg;
        logic dma;
        logic [3:0] tf_addr;
        logic [1:0] lanes;
        logic [10:0] cfg_addr;
    } acc_t;

endpackage : card_host_pkg

// >>> card_host_model.sv
// Host socket model running attribute, memory and I/O cycles on the card pins
`timescale 1ns/1ns
module card_host_model
    import card_host_pkg::*;
(
    // Clock and card data bus
    input wire logic i_clk,
    input wire logic [15:0] i_rdata,
    input wire logic [15:0] i_rdata_oe,
    // Socket pins
    output pin_t o_pins
);
    logic [15:0] rd_q;
    initial o_pins = PIN_IDLE;
    // Select held 4 cycles around the strobe, above the 3 the card needs
    task automatic cyc(input logic [2:0] sel, input logic io, input logic wr, input logic [10:0] a,
                       input logic [15:0] d);
        @(negedge i_clk);
        {o_pins.ce2_n, o_pins.ce1_n, o_pins.reg_n} = sel;
        o_pins.addr = a;
        o_pins.data = d;
        repeat (4) @(negedge i_clk);
        if (io) {o_pins.iord_n, o_pins.iowr_n} = {wr, !wr};
        else {o_pins.oe_n, o_pins.we_n} = {wr, !wr};
        repeat (6) @(negedge i_clk);
        // Floating lanes read as a marker the card never returns
        rd_q = (i_rdata & i_rdata_oe) | (~i_rdata_oe & 16'h5A5A);
        {o_pins.oe_n, o_pins.we_n, o_pins.iord_n, o_pins.iowr_n} = 4'hF;
        repeat (4) @(negedge i_clk);
        {o_pins.ce2_n, o_pins.ce1_n, o_pins.reg_n} = 3'h7;
        // Released bus shows the inverse, not a stale value
        o_pins.data = ~d;
    endtask : cyc
endmodule : card_host_model

// >>> tb_card_host_decode_and_config.sv
// Self-checking bench for the card host decode and configuration block
`timescale 1ns/1ns
module tb_card_host_decode_and_config;
    import card_host_pkg::*;
    logic i_clk = 1'h0;
    logic i_rst = 1'h1;
    logic i_sleeping = 1'h0;
    logic i_irq_req = 1'h0;
    logic i_ide_8bit = 1'h0;
    logic [15:0] i_tf_rdata = 16'hB7A5;
    pin_t pins;
    logic [15:0] o_data, o_data_oe, o_tf_wdata;
    logic [3:0] o_tf_addr;
    logic [1:0] o_tf_be;
    logic o_ready, o_irq, o_card_reset, o_true_ide, o_power_down, o_stschg_n, o_tf_rd, o_tf_wr, o_tf_dma;
    int error_cnt = 0;
    int check_count = 0;
    int n;
    int rd_pulses = 0;
    int wr_pulses = 0;
    // Core ready tied high; the decode is what is under test
    card_host_decode_and_config card_host_decode_and_config_i (
        .i_clk(i_clk), .i_rst(i_rst), .i_ce1_n(pins.ce1_n), .i_ce2_n(pins.ce2_n), .i_reg_n(pins.reg_n),
        .i_oe_n(pins.oe_n), .i_we_n(pins.we_n), .i_iord_n(pins.iord_n), .i_iowr_n(pins.iowr_n),
        .i_dmack_n(pins.dmack_n), .i_reset_pin(pins.rst_pin), .i_addr(pins.addr), .i_data(pins.data),
        .o_data(o_data), .o_data_oe(o_data_oe), .o_ready(o_ready), .o_stschg_n(o_stschg_n), .o_irq(o_irq),
        .i_core_ready(1'h1), .i_sleeping(i_sleeping), .i_irq_req(i_irq_req), .i_ide_8bit(i_ide_8bit),
        .i_tf_rdata(i_tf_rdata), .o_tf_rd(o_tf_rd), .o_tf_wr(o_tf_wr), .o_tf_dma(o_tf_dma), .o_tf_addr(o_tf_addr),
        .o_tf_wdata(o_tf_wdata), .o_tf_be(o_tf_be), .o_card_reset(o_card_reset), .o_true_ide(o_true_ide),
        .o_power_down(o_power_down));
    card_host_model card_host_model_i (.i_clk(i_clk), .i_rdata(o_data), .i_rdata_oe(o_data_oe), .o_pins(pins));
    // Core strobe pulses counted once each, as the core would see them
    always @(negedge i_clk) begin
        rd_pulses += o_tf_rd;
        wr_pulses += o_tf_wr;
    end
    // Clock and watchdog
    initial begin
        forever #50 i_clk = ~i_clk;
    end
    initial begin
        #3000000;
        error_cnt++;
        summarize();
    end
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic summarize();
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : summarize
    // Bus cycles as the host sees them, floating lanes included
    task automatic rd(input logic [2:0] s, input logic io, input logic [10:0] a, input logic [15:0] e,
                      input logic [15:0] m = 16'hFFFF);
        card_host_model_i.cyc(s, io, 1'h0, a, 16'h0000);
        chk("read data", e, card_host_model_i.rd_q & m);
    endtask : rd
    task automatic wr(input logic [2:0] s, input logic io, input logic [10:0] a, input logic [15:0] d);
        card_host_model_i.cyc(s, io, 1'h1, a, d);
    endtask : wr
    task automatic wait_ready();
        for (n = 0; n < 80 && (o_card_reset !== 1'h0 || o_ready !== 1'h1); n++) @(negedge i_clk);
        chk("ready", 16'h0001, {14'h0000, o_card_reset, o_ready});
    endtask : wait_ready
    task automatic t_regs();
        wr(3'h4, 1'h0, SOCKET_ADDR, 16'h00FF);
        rd(3'h4, 1'h0, SOCKET_ADDR, 16'h5A10);
        rd(3'h4, 1'h0, OPT_ADDR, 16'h5A00);
        rd(3'h4, 1'h0, CFGSTAT_ADDR, 16'h5A00, 16'hFF7F);
        wr(3'h4, 1'h0, PINREP_ADDR, 16'h00FF);
        rd(3'h4, 1'h0, PINREP_ADDR, 16'h5A2C, 16'hFFFD);
        wr(3'h4, 1'h0, OPT_ADDR, 16'h0041);
        rd(3'h4, 1'h0, OPT_ADDR, 16'h5A41);
        wr(3'h4, 1'h0, CFGSTAT_ADDR, 16'h0040);
        chk("stschg", 16'h0000, {15'h0000, o_stschg_n});
    endtask : t_regs
    task automatic t_io();
        rd(3'h0, 1'h1, 11'h000, 16'hB7A5);
        rd(3'h4, 1'h1, 11'h000, 16'h5AA5);
        rd(3'h4, 1'h1, 11'h001, 16'h5AA5);
        chk("odd reg", 16'h0001, {12'h000, o_tf_addr});
        rd(3'h2, 1'h1, 11'h000, 16'hB75A);
        rd(3'h6, 1'h1, 11'h000, 16'h5A5A);
        wr(3'h0, 1'h1, 11'h000, 16'h1234);
        chk("word data", 16'h1234, o_tf_wdata);
        chk("word lanes", 16'h0003, {10'h000, o_tf_addr, o_tf_be});
        wr(3'h4, 1'h1, 11'h001, 16'h0056);
        chk("byte write", 16'h5605, {o_tf_wdata[7:0], 2'h0, o_tf_addr, o_tf_be});
        wr(3'h2, 1'h1, 11'h000, 16'hAB00);
        chk("odd write", 16'hAB02, {o_tf_wdata[15:8], 2'h0, o_tf_addr, o_tf_be});
        wr(3'h6, 1'h1, 11'h000, 16'h9999);
        chk("standby write", 16'hAB02, {o_tf_wdata[15:8], 2'h0, o_tf_addr, o_tf_be});
        chk("strobes", 16'h0403, {rd_pulses[7:0], wr_pulses[7:0]});
    endtask : t_io
    task automatic t_map();
        wr(3'h4, 1'h0, OPT_ADDR, 16'h0000);
        rd(3'h1, 1'h0, 11'h000, 16'hB7A5);
        rd(3'h5, 1'h0, 11'h401, 16'h5AA5);
        wr(3'h4, 1'h0, OPT_ADDR, 16'h0002);
        rd(3'h0, 1'h1, 11'h1F0, 16'hB7A5);
        rd(3'h4, 1'h1, 11'h3F6, 16'h5AA5);
        chk("alt reg", 16'h000E, {12'h000, o_tf_addr});
        rd(3'h0, 1'h1, 11'h170, 16'h5A5A);
        wr(3'h4, 1'h0, OPT_ADDR, 16'h0003);
        rd(3'h0, 1'h1, 11'h170, 16'hB7A5);
    endtask : t_map
    task automatic t_srst();
        wr(3'h4, 1'h0, OPT_ADDR, 16'h0080);
        repeat (4) @(negedge i_clk);
        chk("soft reset", 16'h0001, {15'h0000, o_card_reset});
        wr(3'h4, 1'h0, OPT_ADDR, 16'h0000);
        wait_ready();
    endtask : t_srst
    task automatic t_irq();
        wr(3'h4, 1'h0, OPT_ADDR, 16'h0041);
        i_irq_req = 1'h1;
        repeat (6) @(negedge i_clk);
        chk("level irq", 16'h0001, {15'h0000, o_irq});
        wr(3'h4, 1'h1, 11'h00E, 16'h0002);
        chk("masked irq", 16'h0000, {15'h0000, o_irq});
        wr(3'h4, 1'h1, 11'h00E, 16'h0000);
        rd(3'h4, 1'h0, CFGSTAT_ADDR, 16'h5A02, 16'hFF02);
        i_irq_req = 1'h0;
        repeat (6) @(negedge i_clk);
        chk("level drop", 16'h0000, {15'h0000, o_irq});
        wr(3'h4, 1'h0, OPT_ADDR, 16'h0001);
        i_irq_req = 1'h1;
        n = 0;
        repeat (20) @(negedge i_clk) n += (o_irq === 1'h1);
        chk("pulse cycles", 16'h0005, 16'(n));
        i_irq_req = 1'h0;
    endtask : t_irq
    task automatic t_pwd();
        wr(3'h4, 1'h0, CFGSTAT_ADDR, 16'h0004);
        repeat (4) @(negedge i_clk);
        chk("sleep busy", 16'h0002, {14'h0000, o_power_down, o_ready});
        i_sleeping = 1'h1;
        repeat (8) @(negedge i_clk);
        chk("sleep ready", 16'h0003, {14'h0000, o_power_down, o_ready});
        i_sleeping = 1'h0;
    endtask : t_pwd
    task automatic t_ide();
        i_rst = 1'h1;
        card_host_model_i.o_pins.oe_n = 1'h0;
        card_host_model_i.o_pins.rst_pin = 1'h1;
        repeat (20) @(negedge i_clk);
        i_rst = 1'h0;
        repeat (10) @(negedge i_clk);
        card_host_model_i.o_pins.oe_n = 1'h1;
        wait_ready();
        chk("ide mode", 16'h0001, {15'h0000, o_true_ide});
        rd(3'h5, 1'h1, 11'h000, 16'hB7A5);
        rd(3'h5, 1'h1, 11'h003, 16'h5AA5);
        rd(3'h3, 1'h1, 11'h006, 16'h5AA5);
        rd(3'h1, 1'h1, 11'h000, 16'h5A5A);
        rd(3'h4, 1'h0, OPT_ADDR, 16'h5A5A);
        card_host_model_i.o_pins.dmack_n = 1'h0;
        rd(3'h7, 1'h1, 11'h000, 16'hB7A5);
        chk("dma", 16'h0001, {15'h0000, o_tf_dma});
        card_host_model_i.o_pins.dmack_n = 1'h1;
        i_ide_8bit = 1'h1;
        rd(3'h5, 1'h1, 11'h000, 16'h5AA5);
    endtask : t_ide
    // Main sequence
    initial begin
        repeat (20) @(negedge i_clk);
        i_rst = 1'h0;
        wait_ready();
        t_regs();
        t_io();
        t_map();
        t_srst();
        t_irq();
        t_pwd();
        t_ide();
        summarize();
    end
endmodule : tb_card_host_decode_and_config
